/* File: pkg/temp_conv_regs.vh */
/*
 * Byte addresses, configuration bit positions, reset and factory
 * values and timing counts of the conversion and result register logic.
 * Assumes a 10 MHz core clock; included by its bare name.
 */
`ifndef TEMP_CONV_REGS_VH
`define TEMP_CONV_REGS_VH

// ----------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------
`define ADDR_UPPER_HI 8'hA0
`define ADDR_UPPER_LO 8'hA1
`define ADDR_LOWER_HI 8'hA2
`define ADDR_LOWER_LO 8'hA3
`define ADDR_USER_0 8'hA4
`define ADDR_USER_3 8'hA7
`define ADDR_TEMP_HI 8'hAA
`define ADDR_TEMP_LO 8'hAB
`define ADDR_CFG_HI 8'hAC
`define ADDR_CFG_LO 8'hAD

// ----------------------------------------------------------------
// configuration field positions, within their byte
// ----------------------------------------------------------------
`define CFG_DONE_BIT 7
`define CFG_NVB_BIT 6
`define CFG_THF_BIT 5
`define CFG_TLF_BIT 4
`define CFG_RES_HI_BIT 3
`define CFG_RES_LO_BIT 2
`define CFG_AUTO_CONVERT_BIT 1
`define CFG_ONESHOT_BIT 0
`define CFG_PO2_BIT 7
`define CFG_PO1_BIT 6

// ----------------------------------------------------------------
// reset and factory values
// ----------------------------------------------------------------
`define TEMP_RESET 16'hE200
`define UPPER_FACTORY 16'h0780
`define LOWER_FACTORY 16'h0500
`define RES_RESET 2'h3
`define AUTO_CONVERT_RESET 1'h1
`define ONESHOT_RESET 1'h0
`define PO2_RESET 1'h1
`define PO1_RESET 1'h1
`define START_CODE_DEF 8'hA5
`define STOP_CODE_DEF 8'h5A

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CORE_CLK_KHZ 22'h002710
`define CONV_10B_TIME_MS 22'h000019
`define NV_WRITE_TIME_MS 22'h00000A
`define CONV_10B_CYCLES (`CONV_10B_TIME_MS * `CORE_CLK_KHZ)
`define NV_WRITE_CYCLES (`NV_WRITE_TIME_MS * `CORE_CLK_KHZ)

`endif

/* File: rtl/conv_timer.v */
/*
 * Conversion duration timer: counts the 10-bit base time shifted
 * left by the resolution code and pulses expired at the end.
 * Assumes load and abort come from logic on core_clk.
 */
`timescale 1ns/100ps
`include "temp_conv_regs.vh"

module conv_timer #(
  parameter [21:0] BASE_CYCLES = `CONV_10B_CYCLES
) (
  input wire core_clk,
  input wire resetn,
  input wire load,
  input wire abort,
  input wire [1:0] res_sel,
  output reg expired
);

  reg [21:0] count_q;
  reg running_q;

  // ----------------------------------------------------------------
  // count down
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= 22'h000000;
      running_q <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (abort) begin
        running_q <= 1'b0;
      end else if (load) begin
        count_q <= (BASE_CYCLES << res_sel) - 22'h000001;
        running_q <= 1'b1;
      end else if (running_q) begin
        if (count_q == 22'h000000) begin
          expired <= 1'b1;
          running_q <= 1'b0;
        end else begin
          count_q <= count_q - 22'h000001;
        end
      end
    end
  end

endmodule // conv_timer

/* File: rtl/temp_conv_ctrl.v */
/*
 * Conversion sequencing, temperature result, trip-point and
 * configuration registers of the thermometer, reached by byte
 * address from the serial bus engine.
 * Assumes the byte port and command strobe come from the bus engine
 * on core_clk; the converter word arrives from another domain and
 * stays stable across the end of a conversion.
 */
`timescale 1ns/100ps
`include "temp_conv_regs.vh"

module temp_conv_ctrl #(
  parameter [21:0] CONV_BASE_CYCLES = `CONV_10B_CYCLES,
  parameter [21:0] NV_WRITE_CYCLES = `NV_WRITE_CYCLES,
  parameter [7:0] START_CODE = `START_CODE_DEF,
  parameter [7:0] STOP_CODE = `STOP_CODE_DEF
) (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] mem_addr,
  input wire mem_wr,
  input wire [7:0] mem_wdata,
  output reg [7:0] mem_rdata,
  input wire cmd_stb,
  input wire [7:0] cmd_code,
  input wire [12:0] adc_word,
  output reg adc_enable,
  output reg conv_complete,
  output reg nv_busy,
  output reg programmable_output,
  output reg programmable_output_oe_n
);

  // ----------------------------------------------------------------
  // states and storage
  // ----------------------------------------------------------------
  localparam ST_STANDBY = 1'b0;
  localparam ST_CONVERT = 1'b1;

  reg state_q;
  reg pwrup_q;
  reg [15:0] temp_q;
  reg [15:0] upper_trip_threshold_q;
  reg [15:0] lower_trip_threshold_q;
  reg [7:0] user_q [0:3];
  reg done_q;
  reg thf_q;
  reg tlf_q;
  reg [1:0] res_q;
  reg auto_convert_at_powerup_q;
  reg single_conversion_select_q;
  reg po2_q;
  reg po1_q;
  reg therm_active_q;
  reg [21:0] nv_cnt_q;
  reg [12:0] adc_meta_q;
  reg [12:0] adc_sync_q;
  reg [7:0] rdata_d;

  wire timer_expired;
  wire start_cmd;
  wire stop_cmd;
  wire conv_start;
  wire conv_end;
  wire stop_now;
  wire nv_ok;
  wire temp_lo_wr;
  wire eval_en;
  wire [15:0] new_temp;
  wire [15:0] eval_val;
  wire at_or_above;
  wire at_or_below;
  wire [1:0] user_idx;

  // ----------------------------------------------------------------
  // resolution mask
  // ----------------------------------------------------------------
  function [15:0] res_mask;
    input [1:0] res;
    begin
      case (res)
        2'h0: res_mask = 16'hFFC0;
        2'h1: res_mask = 16'hFFE0;
        2'h2: res_mask = 16'hFFF0;
        default: res_mask = 16'hFFF8;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // converter word synchroniser
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      adc_meta_q <= 13'h0000;
      adc_sync_q <= 13'h0000;
    end else begin
      adc_meta_q <= adc_word;
      adc_sync_q <= adc_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign start_cmd = cmd_stb && (cmd_code == START_CODE);
  assign stop_cmd = cmd_stb && (cmd_code == STOP_CODE);
  assign conv_start = (state_q == ST_STANDBY) &&
    (start_cmd || (pwrup_q && auto_convert_at_powerup_q));
  assign conv_end = (state_q == ST_CONVERT) && timer_expired;
  assign stop_now = (state_q == ST_CONVERT) && stop_cmd;
  assign nv_ok = (nv_cnt_q == 22'h000000);
  assign temp_lo_wr = mem_wr && (mem_addr == `ADDR_TEMP_LO);
  // a host write counts only while no conversion runs
  assign eval_en = conv_end ||
    (temp_lo_wr && (state_q == ST_STANDBY));
  // sign in bit 15, one degree at bit 8
  assign new_temp = {adc_sync_q, 3'h0} & res_mask(res_q);
  assign eval_val = conv_end ? new_temp :
    {temp_q[15:8], mem_wdata[7:3], 3'h0};
  assign at_or_above =
    ($signed(eval_val) >= $signed(upper_trip_threshold_q));
  assign at_or_below =
    ($signed(eval_val) <= $signed(lower_trip_threshold_q));
  assign user_idx = mem_addr[1:0];

  // ----------------------------------------------------------------
  // conversion timer
  // ----------------------------------------------------------------
  conv_timer #(
    .BASE_CYCLES(CONV_BASE_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(conv_start || (conv_end && !single_conversion_select_q)),
    .abort(stop_now),
    .res_sel(res_q),
    .expired(timer_expired)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_STANDBY;
      pwrup_q <= 1'b1;
      adc_enable <= 1'b0;
      conv_complete <= 1'b0;
      done_q <= 1'b0;
    end else begin
      pwrup_q <= 1'b0;
      conv_complete <= conv_end;
      case (state_q)
        ST_STANDBY: begin
          if (conv_start) begin
            state_q <= ST_CONVERT;
            done_q <= 1'b0;
          end
        end
        ST_CONVERT: begin
          if (stop_now) begin
            state_q <= ST_STANDBY;
          end else if (conv_end) begin
            done_q <= 1'b1;
            if (single_conversion_select_q) begin
              state_q <= ST_STANDBY;
            end
          end
        end
        default: begin
          state_q <= ST_STANDBY;
        end
      endcase
      adc_enable <= (state_q == ST_CONVERT) && !stop_now &&
        !(conv_end && single_conversion_select_q) || conv_start;
    end
  end

  // ----------------------------------------------------------------
  // temperature result
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      temp_q <= `TEMP_RESET;
    end else if (conv_end) begin
      temp_q <= new_temp;
    end else if (mem_wr && (mem_addr == `ADDR_TEMP_HI)) begin
      temp_q[15:8] <= mem_wdata;
    end else if (temp_lo_wr) begin
      temp_q[7:0] <= {mem_wdata[7:3], 3'h0};
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile registers and write timer
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      upper_trip_threshold_q <= `UPPER_FACTORY;
      lower_trip_threshold_q <= `LOWER_FACTORY;
      res_q <= `RES_RESET;
      auto_convert_at_powerup_q <= `AUTO_CONVERT_RESET;
      single_conversion_select_q <= `ONESHOT_RESET;
      po1_q <= `PO1_RESET;
      nv_cnt_q <= 22'h000000;
      nv_busy <= 1'b0;
      user_q[0] <= 8'h00;
      user_q[1] <= 8'h00;
      user_q[2] <= 8'h00;
      user_q[3] <= 8'h00;
    end else begin
      nv_busy <= !nv_ok;
      if (!nv_ok) begin
        nv_cnt_q <= nv_cnt_q - 22'h000001;
      end else if (mem_wr) begin
        case (mem_addr)
          `ADDR_UPPER_HI: upper_trip_threshold_q[15:8] <= mem_wdata;
          `ADDR_UPPER_LO: upper_trip_threshold_q[7:0] <=
            {mem_wdata[7:3], 3'h0};
          `ADDR_LOWER_HI: lower_trip_threshold_q[15:8] <= mem_wdata;
          `ADDR_LOWER_LO: lower_trip_threshold_q[7:0] <=
            {mem_wdata[7:3], 3'h0};
          `ADDR_CFG_HI: begin
            res_q <= {mem_wdata[`CFG_RES_HI_BIT],
              mem_wdata[`CFG_RES_LO_BIT]};
            auto_convert_at_powerup_q <= mem_wdata[`CFG_AUTO_CONVERT_BIT];
            single_conversion_select_q <= mem_wdata[`CFG_ONESHOT_BIT];
          end
          `ADDR_CFG_LO: po1_q <= mem_wdata[`CFG_PO1_BIT];
          default: begin
            if (mem_addr >= `ADDR_USER_0 && mem_addr <= `ADDR_USER_3) begin
              user_q[user_idx] <= mem_wdata;
            end
          end
        endcase
        if ((mem_addr >= `ADDR_UPPER_HI && mem_addr <= `ADDR_USER_3) ||
            mem_addr == `ADDR_CFG_HI || mem_addr == `ADDR_CFG_LO) begin
          nv_cnt_q <= NV_WRITE_CYCLES - 22'h000001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // flags, output mode and thermostat state
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      thf_q <= 1'b0;
      tlf_q <= 1'b0;
      po2_q <= `PO2_RESET;
      therm_active_q <= 1'b0;
      programmable_output <= 1'b0;
      programmable_output_oe_n <= 1'b1;
    end else begin
      programmable_output <= 1'b0;
      if (mem_wr && mem_addr == `ADDR_CFG_LO) begin
        po2_q <= mem_wdata[`CFG_PO2_BIT];
      end
      // a set in the same cycle wins over a clear
      if (eval_en && at_or_above) begin
        thf_q <= 1'b1;
      end else if (mem_wr && mem_addr == `ADDR_CFG_HI) begin
        thf_q <= thf_q & mem_wdata[`CFG_THF_BIT];
      end
      if (eval_en && at_or_below) begin
        tlf_q <= 1'b1;
      end else if (mem_wr && mem_addr == `ADDR_CFG_HI) begin
        tlf_q <= tlf_q & mem_wdata[`CFG_TLF_BIT];
      end
      if (eval_en) begin
        if (po1_q) begin
          if (at_or_above) begin
            therm_active_q <= 1'b1;
          end else if (at_or_below) begin
            therm_active_q <= 1'b0;
          end
        end else begin
          if (at_or_below) begin
            therm_active_q <= 1'b1;
          end else if (at_or_above) begin
            therm_active_q <= 1'b0;
          end
        end
      end
      programmable_output_oe_n <= po2_q ? !therm_active_q : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = 8'h00;
    case (mem_addr)
      `ADDR_UPPER_HI: rdata_d = upper_trip_threshold_q[15:8];
      `ADDR_UPPER_LO: rdata_d = upper_trip_threshold_q[7:0];
      `ADDR_LOWER_HI: rdata_d = lower_trip_threshold_q[15:8];
      `ADDR_LOWER_LO: rdata_d = lower_trip_threshold_q[7:0];
      `ADDR_TEMP_HI: rdata_d = temp_q[15:8];
      `ADDR_TEMP_LO: rdata_d = temp_q[7:0];
      `ADDR_CFG_HI: rdata_d = {done_q, !nv_ok, thf_q, tlf_q, res_q,
        auto_convert_at_powerup_q, single_conversion_select_q};
      `ADDR_CFG_LO: rdata_d = {po2_q, po1_q, 6'h00};
      default: begin
        if (mem_addr >= `ADDR_USER_0 && mem_addr <= `ADDR_USER_3) begin
          rdata_d = user_q[user_idx];
        end
      end
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_rdata <= 8'h00;
    end else begin
      mem_rdata <= rdata_d;
    end
  end

endmodule // temp_conv_ctrl

/* File: verification/temp_conv_monitor.sv */
/* checker on the ports of the conversion control block;
   assumes it is bound onto temp_conv_ctrl */
`timescale 1ns/100ps
module temp_conv_monitor #(
  parameter int CONV_BASE_CYCLES = 20,
  parameter [7:0] START_CODE = 8'hA5,
  parameter [7:0] STOP_CODE = 8'h5A
) (
  input wire core_clk,
  input wire resetn,
  input wire [7:0] mem_addr,
  input wire mem_wr,
  input wire [7:0] mem_rdata,
  input wire cmd_stb,
  input wire [7:0] cmd_code,
  input wire adc_enable,
  input wire conv_complete,
  input wire nv_busy,
  input wire programmable_output,
  input wire programmable_output_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  localparam int T_MIN = CONV_BASE_CYCLES - 2;
  localparam int T_MAX = CONV_BASE_CYCLES * 8 + 6;
  // --------------------------------
  // cycles of the running conversion
  // --------------------------------
  int run_q;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) run_q <= 0;
    else run_q <= (adc_enable && !conv_complete) ? run_q + 1 : 0;
  end
  sequence s_start_cmd;
    cmd_stb && cmd_code == START_CODE && !adc_enable;
  endsequence
  sequence s_busy_run;
    nv_busy [*8] ##[1:4] !nv_busy;
  endsequence
  // --------------------------------
  // assertions
  // --------------------------------
  a_start_runs: assert property (s_start_cmd |=> adc_enable)
    else $error("start did not begin a conversion");
  a_stop_halts: assert property (
    cmd_stb && cmd_code == STOP_CODE && adc_enable |=> !adc_enable)
    else $error("stop did not end conversions");
  a_conv_length: assert property (
    conv_complete |-> run_q inside {[T_MIN:T_MAX]})
    else $error("conversion length out of range");
  a_done_pulse: assert property (conv_complete |=> !conv_complete)
    else $error("completion pulse too long");
  a_done_cause: assert property (conv_complete |-> $past(adc_enable))
    else $error("completion without conversion");
  a_temp_low_zero: assert property (
    $past(mem_addr) == 8'hAB |-> mem_rdata[2:0] == 3'h0)
    else $error("result low bits not zero");
  a_trip_low_zero: assert property (
    $past(mem_addr) == 8'hA1 || $past(mem_addr) == 8'hA3
    |-> mem_rdata[2:0] == 3'h0)
    else $error("trip low bits not zero");
  a_output_open_drain: assert property (programmable_output == 1'b0)
    else $error("output data not low");
  a_output_cause: assert property (
    $changed(programmable_output_oe_n) |->
    $past(mem_wr) || $past(mem_wr, 2) || $past(mem_wr, 3)
    || conv_complete || $past(conv_complete) || $past(conv_complete, 2))
    else $error("output changed without cause");
  a_nv_busy_time: assert property ($rose(nv_busy) |-> s_busy_run)
    else $error("nonvolatile write time wrong");
  a_nv_busy_cause: assert property (
    $rose(nv_busy) |-> $past(mem_wr) || $past(mem_wr, 2))
    else $error("busy without a write");
endmodule // temp_conv_monitor

bind temp_conv_ctrl temp_conv_monitor #(
  .CONV_BASE_CYCLES(CONV_BASE_CYCLES),
  .START_CODE(START_CODE),
  .STOP_CODE(STOP_CODE)
) i_mon (
  .core_clk(core_clk),
  .resetn(resetn),
  .mem_addr(mem_addr),
  .mem_wr(mem_wr),
  .mem_rdata(mem_rdata),
  .cmd_stb(cmd_stb),
  .cmd_code(cmd_code),
  .adc_enable(adc_enable),
  .conv_complete(conv_complete),
  .nv_busy(nv_busy),
  .programmable_output(programmable_output),
  .programmable_output_oe_n(programmable_output_oe_n)
);

/* File: verification/host_model.sv */
/* host model: byte register port and command strobe;
   assumes core_clk from the bench */
`timescale 1ns/100ps
module host_model (
  input wire core_clk,
  input wire [7:0] mem_rdata,
  output reg [7:0] mem_addr,
  output reg mem_wr,
  output reg [7:0] mem_wdata,
  output reg cmd_stb,
  output reg [7:0] cmd_code
);
  initial begin
    mem_addr = 8'hA8;
    mem_wr = 1'b0;
    mem_wdata = 8'h00;
    cmd_stb = 1'b0;
    cmd_code = 8'h00;
  end
  // --------------------------------
  // bus tasks
  // --------------------------------
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge core_clk);
    mem_wr <= 1'b0;
    mem_wdata <= ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge core_clk);
    mem_addr <= a;
    @(posedge core_clk);
    @(posedge core_clk);
    d = mem_rdata;
  endtask
  task wr16(input [7:0] a, input [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h01, v[7:0]);
  endtask
  task cmd(input [7:0] c);
    @(posedge core_clk);
    cmd_code <= c;
    cmd_stb <= 1'b1;
    @(posedge core_clk);
    cmd_stb <= 1'b0;
    cmd_code <= ~c;
  endtask
endmodule // host_model

/* File: verification/testbench.sv */
/* self-checking bench of the conversion control block;
   assumes host_model and the bound checker */
`timescale 1ns/100ps
module testbench;
  localparam [7:0] START = 8'hA5;
  localparam [7:0] STOP = 8'h5A;
  localparam [127:0] ROWS = 128'hA007_A180_A205_A300_AAE2_AB00_AC0E_A800;
  reg core_clk = 1'b0;
  reg resetn = 1'b0;
  reg [12:0] adc_word = 13'h1E6F;
  wire [7:0] mem_addr, mem_wdata, mem_rdata, cmd_code;
  wire mem_wr, cmd_stb, adc_enable, conv_complete, nv_busy;
  wire programmable_output, programmable_output_oe_n;
  integer fails = 0;
  integer n_tests = 0;
  integer i, n;
  reg [7:0] rv;
  always #50 core_clk = ~core_clk;
  temp_conv_ctrl #(.CONV_BASE_CYCLES(22'h000014),
    .NV_WRITE_CYCLES(22'h00000A), .START_CODE(START), .STOP_CODE(STOP)
  ) i_dut (.core_clk(core_clk), .resetn(resetn), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .cmd_stb(cmd_stb), .cmd_code(cmd_code), .adc_word(adc_word),
    .adc_enable(adc_enable), .conv_complete(conv_complete),
    .nv_busy(nv_busy), .programmable_output(programmable_output),
    .programmable_output_oe_n(programmable_output_oe_n));
  host_model i_host (.core_clk(core_clk), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .cmd_stb(cmd_stb), .cmd_code(cmd_code));
  // --------------------------------
  // helpers
  // --------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wait_for(input integer nv, output integer c);
    c = 0;
    do begin
      @(posedge core_clk);
      c = c + 1;
    // busy shows one edge after the write is taken
    end while ((nv ? (nv_busy !== 1'b0 || c < 2) : conv_complete !== 1'b1)
      && c < 2000);
    if (c >= 2000) begin
      fails = fails + 1;
      $display("BAD %0t wait ran out", $time);
      print_verdict;
    end
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      i_host.rd(ROWS[127-16*i -: 8], rv);
      check(rv, ROWS[119-16*i -: 8]);
    end
    check(adc_enable, 1'b1);
    i_host.cmd(STOP);
    @(posedge core_clk);
    check(adc_enable, 1'b0);
    $display("reset test done");
    i_host.wr16(8'hAA, 16'h1237);
    i_host.rd(8'hAA, rv);
    check(rv, 8'h12);
    i_host.rd(8'hAB, rv);
    check(rv, 8'h30);
    i_host.wr(8'hA1, 8'hFF);
    i_host.wr(8'hA3, 8'hFF);
    wait_for(1, n);
    check(n >= 6 && n <= 14, 1'b1);
    i_host.rd(8'hA1, rv);
    check(rv, 8'hF8);
    i_host.rd(8'hA3, rv);
    check(rv, 8'h00);
    $display("register test done");
    for (i = 0; i < 4; i = i + 1) begin
      i_host.wr(8'hAC, {4'h0, i[1:0], 2'h2});
      wait_for(1, n);
      i_host.cmd(START);
      wait_for(0, n);
      check(n >= (20 << i) && n <= (20 << i) + 6, 1'b1);
      i_host.wr16(8'hAA, 16'h1111);
      wait_for(0, n);
      i_host.cmd(STOP);
      i_host.rd(8'hAA, rv);
      check(rv, 8'hF3);
      i_host.rd(8'hAB, rv);
      check(rv, 8'h78 & (8'hF8 << (3 - i)));
    end
    $display("resolution test done");
    i_host.wr(8'hAC, 8'h0F);
    wait_for(1, n);
    i_host.cmd(START);
    wait_for(0, n);
    n = 0;
    repeat (400) begin
      @(posedge core_clk);
      if (conv_complete === 1'b1) n = n + 1;
    end
    check(n, 0);
    check(adc_enable, 1'b0);
    i_host.cmd(START);
    @(posedge core_clk);
    check(adc_enable, 1'b1);
    wait_for(0, n);
    $display("single conversion test done");
    i_host.wr(8'hAC, 8'h0E);
    wait_for(1, n);
    i_host.cmd(START);
    i_host.wr16(8'hAA, 16'h1000);
    repeat (3) @(posedge core_clk);
    check(programmable_output_oe_n, 1'b1);
    wait_for(0, n);
    i_host.cmd(STOP);
    i_host.wr(8'hAA, 8'h10);
    repeat (3) @(posedge core_clk);
    check(programmable_output_oe_n, 1'b1);
    i_host.wr(8'hAB, 8'h00);
    repeat (3) @(posedge core_clk);
    check(programmable_output_oe_n, 1'b0);
    i_host.rd(8'hAC, rv);
    check(rv, 8'hBE);
    i_host.wr(8'hAD, 8'h80);
    wait_for(1, n);
    i_host.wr(8'hAB, 8'h00);
    repeat (3) @(posedge core_clk);
    check(programmable_output_oe_n, 1'b1);
    i_host.wr(8'hAD, 8'h00);
    repeat (3) @(posedge core_clk);
    check(programmable_output_oe_n, 1'b0);
    $display("output test done");
    resetn <= 1'b0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    i_host.rd(8'hAA, rv);
    check(rv, 8'hE2);
    check(adc_enable, 1'b1);
    check(programmable_output_oe_n, 1'b1);
    i_host.rd(8'hAC, rv);
    check(rv, 8'h0E);
    $display("mid-run reset test done");
    print_verdict;
  end
endmodule // testbench
